// >>> hdl/swl_burst_fifo.sv
/*
 Small FIFO holding write burst records between capture and the
 array. Assumes a synchronous active-high reset on clk_i.
*/
`timescale 1ns/10ps
`default_nettype none

module swl_burst_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,            // System clock
   input wire logic rst_i,            // Synchronous reset
   swl_burst_if.snk in_if,            // Fill side
   swl_burst_if.src out_if,           // Drain side
   output logic [$clog2(DEPTH+1)-1:0] level_o // Entries held
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [W-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [CNT_W-1:0] count_reg;
   logic push;
   logic pop;

   // ----------------------------------------------------------------
   // Flags and handshakes
   // ----------------------------------------------------------------
   assign in_if.ready = (count_reg != CNT_W'(DEPTH));
   assign out_if.valid = (count_reg != '0);
   assign out_if.data = store[rd_ptr_reg];
   assign push = in_if.valid & in_if.ready;
   assign pop = out_if.valid & out_if.ready;
   assign level_o = count_reg;

   // Storage write
   always_ff @(posedge clk_i) begin
      if (push) begin
         store[wr_ptr_reg] <= in_if.data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                          : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                          : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
      end
   end

endmodule // swl_burst_fifo

`default_nettype wire

// >>> hdl/swl_burst_if.sv
/*
 Valid/ready channel carrying one packed write burst record.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none

interface swl_burst_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// >>> hdl/swl_pin_sync.sv
/*
 Two-stage synchroniser for a bundle of pins from outside the clock
 domain. Assumes pins are static relative to link edges for several
 system clocks; no reset, so pin levels are seen during reset too.
*/
`timescale 1ns/10ps
`default_nettype none

module swl_pin_sync #(parameter int W = 1) (
   input wire logic clk_i,         // System clock
   input wire logic [W-1:0] pin_i, // Asynchronous pins
   output logic [W-1:0] pin_o      // Synchronised pins
);

   // ----------------------------------------------------------------
   // Per-bit double flop
   // ----------------------------------------------------------------
   for (genvar g = 0; g < W; g++) begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // First stage feeds only the second
      always_ff @(posedge clk_i) begin
         meta_reg <= pin_i[g];
         sync_reg <= meta_reg;
      end
      assign pin_o[g] = sync_reg;
   end

endmodule // swl_pin_sync

`default_nettype wire

// >>> hdl/swl_pkg.sv
/*
 Shared constants, burst record type and read state encoding for the
 write lane mask block of a burst-of-two double data rate SRAM model.
 Assumes a single system clock and a classic Wishbone register slave.
*/
// Summary of operation
// - Lane selects sampled per beat, gate lanes
// - x8: nibble selects gate bits 3:0, 7:4
// - x18: byte selects gate bits 8:0, 17:9
// - x9: one select governs whole 9-bit beat
// - x36: four selects gate four 9-bit lanes
// - x36: all selects low write full word
// - All selects high: beat writes nothing
// - Each beat uses its own select pattern
// - Data captured on both input clock rises
// - Output clocks time reads, else input clocks
// - Powers up deselected, outputs high impedance
// - Burst words go to A and A+1
// - Write begins with port select low on rise
// - Read words at t+1.5 and t+2 edges
package swl_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int NIB_W = 4;
   localparam int BYTE_W = 9;
   localparam int WORDS = 2 ** (ADDR_W + 1);
   localparam int BUF_DEPTH = 2;
   localparam int PIN_W = 6 + ADDR_W + LANES + DATA_W;

   // Organisation codes
   localparam logic [1:0] ORG_X8 = 2'h0;
   localparam logic [1:0] ORG_X9 = 2'h1;
   localparam logic [1:0] ORG_X18 = 2'h2;
   localparam logic [1:0] ORG_X36 = 2'h3;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int WB_ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_WRCOUNT = 4'h8;
   localparam logic [3:0] REG_LASTADDR = 4'hC;
   localparam int CTRL_ORG_LSB = 0;
   localparam int CTRL_WREN_BIT = 2;
   localparam int STATUS_SINGLE_BIT = 0;
   localparam int STATUS_RDBUSY_BIT = 1;
   localparam int STATUS_PEND_BIT = 2;
   localparam int STATUS_OVF_BIT = 3;
   localparam logic [1:0] CTRL_ORG_RST = ORG_X36;
   localparam logic CTRL_WREN_RST = 1'h1;
   localparam logic [15:0] WRCOUNT_RST = 16'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] d0;
      logic [DATA_W-1:0] e0;
      logic [DATA_W-1:0] d1;
      logic [DATA_W-1:0] e1;
   } swl_burst_t;

   localparam int BURST_W = $bits(swl_burst_t);

   typedef enum logic [2:0] {
      RD_IDLE = 3'h0,
      RD_WAIT = 3'h1,
      RD_ARM = 3'h2,
      RD_FIRST = 3'h3,
      RD_SECOND = 3'h4
   } swl_rd_state_t;

endpackage

// >>> hdl/swl_write_lane_mask.sv
/*
 Write port lane masking and burst-of-two array of a DDR SRAM model,
 with a read port and a Wishbone register slave. Assumes link clocks
 are far slower than clk_i (several clk_i cycles per link half period)
 and are sampled as ordinary pins.
*/
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module swl_write_lane_mask
   import swl_pkg::*;
(
   input wire logic clk_i,                      // System clock 20 MHz
   input wire logic rst_i,                      // Sync reset, high
   input wire logic k_i,                        // Input clock
   input wire logic k_n_i,                      // Inverted input clock
   input wire logic c_i,                        // Output clock
   input wire logic c_n_i,                      // Inverted output clock
   input wire logic write_port_select_n_i,      // Write select, low
   input wire logic read_port_select_n_i,       // Read select, low
   input wire logic [ADDR_W-1:0] addr_i,        // Burst address
   input wire logic [LANES-1:0] byte_lane_select_n_i, // Lane selects
   input wire logic [DATA_W-1:0] d_i,           // Write data
   output logic [DATA_W-1:0] q_o,               // Read data
   output logic q_oe_n_o,                       // Read data enable, low
   input wire logic wb_cyc_i,                   // Wishbone cycle
   input wire logic wb_stb_i,                   // Wishbone strobe
   input wire logic wb_we_i,                    // Wishbone write
   input wire logic [WB_ADDR_W-1:0] wb_adr_i,   // Byte address
   input wire logic [3:0] wb_sel_i,             // Byte enables
   input wire logic [31:0] wb_dat_i,            // Write data
   output logic [31:0] wb_dat_o,                // Read data
   output logic wb_ack_o                        // Acknowledge
);

   // ----------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] pins_s;
   logic k_s, kn_s, c_s, cn_s, wps_n_s, rps_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [LANES-1:0] sel_n_s;
   logic [DATA_W-1:0] d_s;
   logic [3:0] clk_prev_reg;
   logic k_rise, kn_rise, c_rise, cn_rise;

   assign pins_raw = {k_i, k_n_i, c_i, c_n_i, write_port_select_n_i,
                      read_port_select_n_i, addr_i, byte_lane_select_n_i,
                      d_i};

   swl_pin_sync #(.W(PIN_W)) u_sync (
      .clk_i(clk_i),
      .pin_i(pins_raw),
      .pin_o(pins_s)
   );

   assign {k_s, kn_s, c_s, cn_s, wps_n_s, rps_n_s, addr_s, sel_n_s,
           d_s} = pins_s;

   // Previous clock levels; start high so a parked clock is no edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_prev_reg <= 4'hF;
      end else begin
         clk_prev_reg <= {k_s, kn_s, c_s, cn_s};
      end
   end

   assign k_rise = k_s & ~clk_prev_reg[3];
   assign kn_rise = kn_s & ~clk_prev_reg[2];
   assign c_rise = c_s & ~clk_prev_reg[1];
   assign cn_rise = cn_s & ~clk_prev_reg[0];

   // ----------------------------------------------------------------
   // Registers and single clock strap
   // ----------------------------------------------------------------
   logic [1:0] org_reg;
   logic wr_en_reg;
   logic ovf_reg;
   logic strap_done_reg;
   logic single_clk_reg;
   logic [15:0] wr_count_reg;
   logic [ADDR_W-1:0] last_addr_reg;
   logic oclk_rise, oclk_n_rise;

   // Strap is caught once after reset release, never under reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_done_reg <= 1'b0;
         single_clk_reg <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         single_clk_reg <= c_s & cn_s;
      end
   end

   // Output timing reference selection
   assign oclk_rise = single_clk_reg ? k_rise : c_rise;
   assign oclk_n_rise = single_clk_reg ? kn_rise : cn_rise;

   // ----------------------------------------------------------------
   // Lane enables, one decision per data bit
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] lane_en;

   for (genvar b = 0; b < DATA_W; b++) begin : g_lane
      localparam int NL = (b < 2 * NIB_W) ? b / NIB_W : 0;
      localparam int BL = b / BYTE_W;
      logic en_x8, en_x9, en_x18, en_x36;
      assign en_x8 = (b < 2 * NIB_W) && !sel_n_s[NL];
      assign en_x9 = (b < BYTE_W) && !sel_n_s[0];
      assign en_x18 = (b < 2 * BYTE_W) && !sel_n_s[BL];
      assign en_x36 = !sel_n_s[BL];
      assign lane_en[b] = (org_reg == ORG_X8) ? en_x8
                        : (org_reg == ORG_X9) ? en_x9
                        : (org_reg == ORG_X18) ? en_x18 : en_x36;
   end

   // ----------------------------------------------------------------
   // Write beat capture
   // ----------------------------------------------------------------
   logic wr_pend_reg;
   logic [DATA_W-1:0] d0_reg;
   logic [DATA_W-1:0] e0_reg;
   logic accept_wr;
   logic push;
   logic ovf_set;
   swl_burst_t fill_rec;

   swl_burst_if #(.W(BURST_W)) fill_if ();
   swl_burst_if #(.W(BURST_W)) drain_if ();

   assign accept_wr = k_rise & ~wps_n_s & wr_en_reg;
   assign push = wr_pend_reg & kn_rise;
   assign ovf_set = push & ~fill_if.ready;

   // First beat on input clock rise, with its own lane pattern
   always_ff @(posedge clk_i) begin
      if (accept_wr) begin
         d0_reg <= d_s;
         e0_reg <= lane_en;
      end
   end

   // Burst in progress between the two beats
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_pend_reg <= 1'b0;
      end else if (accept_wr) begin
         wr_pend_reg <= 1'b1;
      end else if (kn_rise) begin
         wr_pend_reg <= 1'b0;
      end
   end

   // Second beat and address join the first beat in one record
   assign fill_rec.addr = addr_s;
   assign fill_rec.d0 = d0_reg;
   assign fill_rec.e0 = e0_reg;
   assign fill_rec.d1 = d_s;
   assign fill_rec.e1 = lane_en;
   assign fill_if.valid = push;
   assign fill_if.data = fill_rec;

   swl_burst_fifo #(.W(BURST_W), .DEPTH(BUF_DEPTH)) u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_if(fill_if.snk),
      .out_if(drain_if.src),
      .level_o()
   );

   // ----------------------------------------------------------------
   // Array merge
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] mem [WORDS];
   swl_burst_t drain_rec;
   logic rd_fetch;
   logic fire;
   logic [ADDR_W:0] w0_idx;
   logic [ADDR_W:0] w1_idx;
   logic [DATA_W-1:0] mem0_old;

   assign drain_rec = swl_burst_t'(drain_if.data);
   assign drain_if.ready = ~rd_fetch; // Reads take the array first
   assign fire = drain_if.valid & drain_if.ready;
   assign w0_idx = {drain_rec.addr, 1'b0};
   assign w1_idx = {drain_rec.addr, 1'b1};
   assign mem0_old = mem[w0_idx];

   // Both beats written together, unselected lanes keep old bits
   always_ff @(posedge clk_i) begin
      if (fire) begin
         mem[w0_idx] <= (mem[w0_idx] & ~drain_rec.e0)
                        | (drain_rec.d0 & drain_rec.e0);
         mem[w1_idx] <= (mem[w1_idx] & ~drain_rec.e1)
                        | (drain_rec.d1 & drain_rec.e1);
      end
   end

   // Write statistics
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_count_reg <= WRCOUNT_RST;
         last_addr_reg <= '0;
      end else if (fire) begin
         wr_count_reg <= wr_count_reg + 16'h0001;
         last_addr_reg <= drain_rec.addr;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   swl_rd_state_t rd_state_reg, rd_state_next;
   logic [ADDR_W-1:0] rd_addr_reg;
   logic rd_start;
   logic [DATA_W-1:0] q_reg;
   logic q_oe_n_reg;

   assign rd_start = (rd_state_reg == RD_IDLE) & k_rise & ~rps_n_s;
   assign rd_fetch = ((rd_state_reg == RD_ARM) & oclk_n_rise)
                   | ((rd_state_reg == RD_FIRST) & oclk_rise);

   // Read sequencing on input clock rises (start, wait) then output clock edges
   always_comb begin
      rd_state_next = rd_state_reg;
      case (rd_state_reg)
         RD_IDLE: begin
            if (rd_start) rd_state_next = RD_WAIT;
         end
         RD_WAIT: begin
            if (k_rise) rd_state_next = RD_ARM;
         end
         RD_ARM: begin
            if (oclk_n_rise) rd_state_next = RD_FIRST;
         end
         RD_FIRST: begin
            if (oclk_rise) rd_state_next = RD_SECOND;
         end
         RD_SECOND: begin
            if (oclk_n_rise) rd_state_next = RD_IDLE;
         end
         default: rd_state_next = RD_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_state_reg <= RD_IDLE;
         rd_addr_reg <= '0;
      end else begin
         rd_state_reg <= rd_state_next;
         if (rd_start) rd_addr_reg <= addr_s;
      end
   end

   // Output data and enable; deselected after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_reg <= '0;
         q_oe_n_reg <= 1'b1;
      end else if (rd_state_reg == RD_ARM && oclk_n_rise) begin
         q_reg <= mem[{rd_addr_reg, 1'b0}];
         q_oe_n_reg <= 1'b0;
      end else if (rd_state_reg == RD_FIRST && oclk_rise) begin
         q_reg <= mem[{rd_addr_reg, 1'b1}];
      end else if (rd_state_reg == RD_SECOND && oclk_n_rise) begin
         q_oe_n_reg <= 1'b1;
      end
   end

   assign q_o = q_reg;
   assign q_oe_n_o = q_oe_n_reg;

   // ----------------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------------
   logic wb_hit, wb_wr, hit_ctrl, hit_status, hit_count, hit_last;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] rd_word;

   assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wb_wr = wb_hit & wb_we_i & wb_sel_i[0];
   assign hit_ctrl = (wb_adr_i == REG_CTRL);
   assign hit_status = (wb_adr_i == REG_STATUS);
   assign hit_count = (wb_adr_i == REG_WRCOUNT);
   assign hit_last = (wb_adr_i == REG_LASTADDR);
   assign rd_word = hit_ctrl ? {29'h0, wr_en_reg, org_reg}
      : hit_status ? {28'h0, ovf_reg, drain_if.valid,
                      rd_state_reg != RD_IDLE, single_clk_reg}
      : hit_count ? {16'h0, wr_count_reg}
      : hit_last ? {{(32 - ADDR_W){1'b0}}, last_addr_reg} : 32'h0;

   // One-wait acknowledge and registered read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h0;
      end else begin
         ack_reg <= wb_hit;
         if (wb_hit && !wb_we_i) dat_reg <= rd_word;
      end
   end

   // Control register and sticky overflow, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         org_reg <= CTRL_ORG_RST;
         wr_en_reg <= CTRL_WREN_RST;
         ovf_reg <= 1'b0;
      end else begin
         if (wb_wr && hit_ctrl) begin
            org_reg <= wb_dat_i[CTRL_ORG_LSB +: 2];
            wr_en_reg <= wb_dat_i[CTRL_WREN_BIT];
         end
         if (ovf_set) ovf_reg <= 1'b1;
         else if (wb_wr && hit_status && wb_dat_i[STATUS_OVF_BIT])
            ovf_reg <= 1'b0;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_x8;
      org_reg == ORG_X8 |-> lane_en == {28'h0, {4{~sel_n_s[1]}},
                                        {4{~sel_n_s[0]}}};
   endproperty
   a_x8: assert property (p_x8) else $error("x8 lane map wrong");

   property p_x18;
      org_reg == ORG_X18 |-> lane_en == {18'h0, {9{~sel_n_s[1]}},
                                         {9{~sel_n_s[0]}}};
   endproperty
   a_x18: assert property (p_x18) else $error("x18 lane map wrong");

   property p_x9;
      org_reg == ORG_X9 |-> lane_en == {27'h0, {9{~sel_n_s[0]}}};
   endproperty
   a_x9: assert property (p_x9) else $error("x9 lane map wrong");

   property p_x36;
      org_reg == ORG_X36 && sel_n_s == 4'hB |-> lane_en == 36'h007FC0000;
   endproperty
   a_x36: assert property (p_x36) else $error("x36 lane 2 wrong");

   property p_full;
      org_reg == ORG_X36 && sel_n_s == 4'h0 |-> &lane_en;
   endproperty
   a_full: assert property (p_full) else $error("x36 full write");

   property p_none;
      sel_n_s == 4'hF |-> lane_en == '0;
   endproperty
   a_none: assert property (p_none) else $error("idle beat writes");

   property p_beat0;
      accept_wr |=> wr_pend_reg && e0_reg == $past(lane_en)
                    && d0_reg == $past(d_s);
   endproperty
   a_beat0: assert property (p_beat0) else $error("beat 0 lost");

   // Beat 0 pattern and data must survive until the second beat
   property p_beat1;
      wr_pend_reg && !accept_wr |=> $stable(e0_reg) && $stable(d0_reg);
   endproperty
   a_beat1: assert property (p_beat1) else $error("beat masks mixed");

   property p_merge;
      fire |=> (mem[$past(w0_idx)] & $past(drain_rec.e0))
               == ($past(drain_rec.d0) & $past(drain_rec.e0))
               && (mem[$past(w0_idx)] & ~$past(drain_rec.e0))
               === ($past(mem0_old) & ~$past(drain_rec.e0));
   endproperty
   a_merge: assert property (p_merge) else $error("merge wrong");

   property p_idle_off;
      rd_state_reg == RD_IDLE && $past(rd_state_reg) == RD_IDLE
         |-> q_oe_n_reg;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("q driven");

   property p_read;
      rd_start |-> ##[2:40] !q_oe_n_reg;
   endproperty
   a_read: assert property (p_read) else $error("read late");

   c_write: cover property (fire);
   c_read: cover property (rd_state_reg == RD_SECOND && oclk_n_rise);
   c_ovf: cover property (ovf_set);
   c_partial: cover property (fire && drain_rec.e0 != drain_rec.e1);

endmodule // swl_write_lane_mask

`default_nettype wire

// >>> testbench/swl_ctrl_model.sv
/*
 Memory controller model driving the SRAM link write and read ports.
 Assumes clk_i is the bench clock; a link half period is 4-5 clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module swl_ctrl_model
   import swl_pkg::*;
(
   input wire logic clk_i, // Clock
   input wire logic [DATA_W-1:0] q_i, // Read data
   input wire logic q_oe_n_i, // Read enable
   output logic k_o, // Link clock
   output logic k_n_o, // Inverted link clock
   output logic wr_sel_n_o, // Write select
   output logic rd_sel_n_o, // Read select
   output logic [ADDR_W-1:0] addr_o, // Address
   output logic [LANES-1:0] lane_n_o, // Lane selects
   output logic [DATA_W-1:0] d_o // Write data
);
   // Idle: both clocks held high, ports deselected
   initial begin
      k_o = 1'b1;
      k_n_o = 1'b1;
      wr_sel_n_o = 1'b1;
      rd_sel_n_o = 1'b1;
      addr_o = '0;
      lane_n_o = '1;
      d_o = '0;
   end
   // One half period of the link clock pair
   task automatic hp(input logic v, input int n);
      @(posedge clk_i);
      k_o <= v;
      k_n_o <= ~v;
      repeat (n - 1) @(posedge clk_i);
   endtask
   // Write burst: beat 0 at K rise, beat 1 and address at K_n rise
   task automatic wr(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d0, d1, input logic [LANES-1:0] m0, m1);
      @(posedge clk_i);
      wr_sel_n_o <= 1'b0;
      addr_o <= a;
      d_o <= d0;
      lane_n_o <= m0;
      repeat (3) @(posedge clk_i);
      hp(1'b0, 4);
      hp(1'b1, 2);
      wr_sel_n_o <= 1'b1;
      d_o <= d1;
      lane_n_o <= m1;
      hp(1'b1, 2);
      hp(1'b0, 4);
      d_o <= ~d1; // Released lines stop showing the beat
      lane_n_o <= ~m1;
      addr_o <= ~a;
      k_o <= 1'b1;
   endtask
   // Read burst; words taken a few clocks after the output clock edges
   task automatic rd(input logic [ADDR_W-1:0] a,
      output logic [DATA_W-1:0] w0, w1, output logic oe0, oe1);
      @(posedge clk_i);
      rd_sel_n_o <= 1'b0;
      addr_o <= a;
      repeat (3) @(posedge clk_i);
      hp(1'b0, 4);
      hp(1'b1, 4);
      rd_sel_n_o <= 1'b1;
      addr_o <= ~a;
      hp(1'b0, 4);
      hp(1'b1, 4);
      hp(1'b0, 5);
      w0 = q_i;
      oe0 = q_oe_n_i;
      hp(1'b1, 5);
      w1 = q_i;
      hp(1'b0, 5);
      oe1 = q_oe_n_i;
      k_o <= 1'b1;
   endtask
endmodule // swl_ctrl_model
`default_nettype wire

// >>> testbench/swl_write_lane_mask_test.sv
/*
 Self-checking bench for the lane masked write port with a read back.
 Runs the single clock strap first, then resets with output clocks live.
*/
`timescale 1ns/10ps
`default_nettype none
module swl_write_lane_mask_test;
   import swl_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, rdat, wdo;
   logic k, kn, wsn, rsn, oen, ack, o0, o1;
   logic sm = 1'b1;
   wire logic c = sm | ~kn, cn = sm | ~k; // Strap high, else follow K
   logic [ADDR_W-1:0] a, ad;
   logic [LANES-1:0] m, m0, m1;
   logic [DATA_W-1:0] d, q, w0, w1, old, nw, x0, x1, wm;
   int err_total = 0, n_tests = 0;
   // Clock
   always #25 clk_i = ~clk_i;
   swl_write_lane_mask uut (.clk_i(clk_i), .rst_i(rst_i), .k_i(k),
      .k_n_i(kn), .c_i(c), .c_n_i(cn), .write_port_select_n_i(wsn),
      .read_port_select_n_i(rsn), .addr_i(a), .byte_lane_select_n_i(m),
      .d_i(d), .q_o(q), .q_oe_n_o(oen), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(wdo), .wb_ack_o(ack));
   swl_ctrl_model ctl (.clk_i(clk_i), .q_i(q), .q_oe_n_i(oen), .k_o(k),
      .k_n_o(kn), .wr_sel_n_o(wsn), .rd_sel_n_o(rsn), .addr_o(a),
      .lane_n_o(m), .d_o(d));
   // Lanes written for an organisation and an active low select set
   function automatic logic [DATA_W-1:0] lmask(input logic [1:0] g,
      input logic [LANES-1:0] n);
      case (g)
         ORG_X8: return {28'h0, {4{~n[1]}}, {4{~n[0]}}};
         ORG_X9: return {27'h0, {9{~n[0]}}};
         ORG_X18: return {18'h0, {9{~n[1]}}, {9{~n[0]}}};
         default: return {{9{~n[3]}}, {9{~n[2]}}, {9{~n[1]}}, {9{~n[0]}}};
      endcase
   endfunction
   // Stored word after a masked beat lands on an old word
   function automatic logic [DATA_W-1:0] mrg(input logic [1:0] g,
      input logic [DATA_W-1:0] o, n, input logic [LANES-1:0] s);
      logic [DATA_W-1:0] e;
      e = lmask(g, s);
      return (o & ~e) | (n & e);
   endfunction
   // Verdict and end of run
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Compare seen against expected
   task automatic chk(input string nm, input logic [35:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Classic Wishbone single cycle, read data into rdat
   task automatic wb(input logic w, input logic [3:0] ai,
      input logic [31:0] dw);
      int i;
      i = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ai;
      dat <= dw;
      sel <= 4'hF;
      do begin
         @(posedge clk_i);
         i++;
      end while (ack !== 1'b1 && i < 20);
      rdat = wdo;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 20) begin
         err_total++;
         end_sim;
      end
   endtask
   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_i);
      err_total++;
      end_sim;
   end
   // Main sequence
   initial begin
      void'($urandom(32'hDD77));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("oe_n", {35'h0, oen}, 36'h1);
      wb(1'b0, REG_CTRL, 32'h0);
      chk("ctrl", {4'h0, rdat}, 36'h7);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("status", {4'h0, rdat}, 36'h1);
      wb(1'b1, 4'h2, 32'hFFFFFFFF);
      wb(1'b0, 4'h2, 32'h0);
      chk("unmapped", {4'h0, rdat}, 36'h0);
      $display("test registers done");
      for (int g = 0; g < 4; g++) begin
         wb(1'b1, REG_CTRL, 32'h4 | 32'(g));
         for (int i = 0; i < 3; i++) begin
            ad = ADDR_W'($urandom());
            old = DATA_W'({$urandom(), $urandom()});
            nw = DATA_W'({$urandom(), $urandom()});
            m0 = (i == 0) ? 4'hF : LANES'($urandom());
            m1 = (i == 0) ? 4'h0 : LANES'($urandom());
            wm = lmask(2'(g), 4'h0);
            x0 = mrg(2'(g), old, nw, m0);
            x1 = mrg(2'(g), ~old, ~nw, m1);
            ctl.wr(ad, old, ~old, 4'h0, 4'h0);
            ctl.wr(ad, nw, ~nw, m0, m1);
            ctl.rd(ad, w0, w1, o0, o1);
            chk("word0", w0 & wm, x0 & wm);
            chk("word1", w1 & wm, x1 & wm);
            chk("oe_n read", {34'h0, o0, o1}, 36'h1);
         end
         $display("test org %0d done", g);
      end
      wb(1'b1, REG_CTRL, 32'h3);
      ctl.wr(ad, ~x0, ~x1, 4'h0, 4'h0);
      ctl.rd(ad, w0, w1, o0, o1);
      chk("disabled word0", w0, x0);
      chk("disabled word1", w1, x1);
      wb(1'b0, REG_WRCOUNT, 32'h0);
      chk("wrcount", {4'h0, rdat}, 36'h18);
      wb(1'b0, REG_LASTADDR, 32'h0);
      chk("lastaddr", {4'h0, rdat}, {32'h0, ad});
      $display("test write disable done");
      // Reset again with the output clock pair running off K
      sm <= 1'b0;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("oe_n reset", {35'h0, oen}, 36'h1);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("status dual", {4'h0, rdat}, 36'h0);
      ctl.rd(ad, w0, w1, o0, o1);
      chk("dual word0", w0, x0);
      chk("dual word1", w1, x1);
      chk("dual oe_n", {34'h0, o0, o1}, 36'h1);
      $display("test dual clock done");
      end_sim;
   end
endmodule // swl_write_lane_mask_test
`default_nettype wire
